// [logic/lcd_cfg.svh]
/*
 Command codes, field positions, reset values and fixed patterns of the
 status and charge pump command block.
 Assumes it is included by its bare name by every design file that needs it.
*/
`ifndef LCD_CFG_SVH
`define LCD_CFG_SVH

// Framing
`define RW_READ         1'b1
`define RW_WRITE        1'b0
`define RS_GENERAL      2'h0

// Opcodes
`define CMD_CLEAR_FLAG  8'h1f
`define CMD_INITIALIZE  8'h3a
`define OP_PUMP_CTRL    4'hc
`define OP_READ_SELECT  7'h0e

// Pump command fields
`define PUMP_EN_BIT     3
`define PUMP_MULT_HI    2
`define PUMP_MULT_LO    0

// Status byte bit positions
`define ST_DISPLAY      7
`define ST_PUMP_ON      6
`define ST_PUMP_READY   5
`define ST_RESET_FLAG   4
`define ST_CODE_HI      3
`define ST_CODE_LO      0

// Disturbance check codes
`define CODE_SPI        4'h5
`define CODE_I2C_TOP    2'h1

// Reset values
`define PUMP_EN_RST     1'b0
`define PUMP_MULT_RST   3'h0
`define READ_SEL_RST    1'b0
`define RESET_FLAG_RST  1'b1
`define STATUS_RST      8'h00

// Multiplier codes and resulting gains
`define MULT_X2         3'h0
`define MULT_X3         3'h1
`define MULT_X4         3'h2
`define MULT_X5         3'h3
`define GAIN_X1         3'h1
`define GAIN_X2         3'h2
`define GAIN_X3         3'h3
`define GAIN_X4         3'h4
`define GAIN_X5         3'h5

// Readout select values
`define SEL_TEMPERATURE 1'b0
`define READ_SEL_BIT    0

`endif

// [logic/lcd_cmd_pkg.sv]
/*
 Types shared by the status and charge pump command block.
 Assumes nothing of its surroundings.
*/
package lcd_cmd_pkg;

	typedef struct packed {
		logic       rw;
		logic [1:0] register_group_select;
		logic [7:0] data;
	} cmd_frame_s;

	typedef struct packed {
		logic status_read;
		logic clear_flag;
		logic initialize;
		logic pump_ctrl;
		logic read_select;
	} cmd_decode_s;

	typedef struct packed {
		logic       pump_enable;
		logic [2:0] pump_multiplier;
	} pump_cfg_s;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_EXEC = 1'b1
	} ctl_state_e;

endpackage

// [logic/sync_bits.sv]
/*
 Two flip-flop synchroniser for a vector of independent levels.
 Assumes each bit is stable long enough to be seen by mclk.
*/
`timescale 1ns/1ps
module sync_bits #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			q_reg    <= '0;
		end else begin
			meta_reg <= d;
			q_reg    <= meta_reg;
		end
	end

	assign q = q_reg;

endmodule

// [logic/cmd_decode.sv]
/*
 Combinational decode of one framed command byte.
 Assumes the frame is stable while it is decoded.
*/
`timescale 1ns/1ps
`include "lcd_cfg.svh"
module cmd_decode (
	// Frame in
	input  wire lcd_cmd_pkg::cmd_frame_s  frame,
	// Decoded command
	output lcd_cmd_pkg::cmd_decode_s      dec
);

	logic general_write;

	always_comb begin
		general_write   = (frame.rw == `RW_WRITE) && (frame.register_group_select == `RS_GENERAL);
		dec.status_read = (frame.rw == `RW_READ) && (frame.register_group_select == `RS_GENERAL);
		dec.clear_flag  = general_write && (frame.data == `CMD_CLEAR_FLAG);
		dec.initialize  = general_write && (frame.data == `CMD_INITIALIZE);
		dec.pump_ctrl   = general_write && (frame.data[7:4] == `OP_PUMP_CTRL);
		dec.read_select = general_write && (frame.data[7:1] == `OP_READ_SELECT);
	end

endmodule

// [logic/lcd_status_and_pump_cmds.sv]
/*
 Status readout, reset flag and charge pump control of an LCD segment driver.
 Assumes a serial engine on the link clock presents a framed command (read/write bit,
 group select, byte) with a valid level, held stable across a rising link clock edge.
 All link and pin inputs are asynchronous to mclk and are synchronised here.
*/
// Summary of operation
// - A read with group select 00 asks for one status byte, which the block returns.
// - With readout select 0 the byte is the 8-bit temperature value.
// - With readout select 1, bit 7 shows whether the display is enabled.
// - In device status mode, bit 6 mirrors the pump enable setting.
// - In device status mode, bit 5 shows that the pump reached its programmed voltage.
// - In device status mode, bit 4 is the sticky reset flag, set after power-on.
// - The reset pin, power-on reset and the Initialize command all set the sticky flag.
// - On I2C, bits 3 to 0 read 0, 1 and the two address straps.
// - On SPI, bits 3 to 0 read 0101.
// - Status bits are taken live at the moment of the read.
// - The write 00011111 with group select 00 clears the sticky flag.
// - A write with group select 00 and upper nibble 1100 loads pump enable and multiplier.
// - Pump command bit 3 set turns the internal pump on, clear leaves it off.
// - Pump bits 2 to 0 pick x2, x3, x4, x5, or x1 direct mode for codes 100 to 111.
// - A write with bits 7 to 1 equal 0001110 stores bit 0 as readout select.
`timescale 1ns/1ps
`include "lcd_cfg.svh"
module lcd_status_and_pump_cmds (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// Command link
	input  wire logic       link_clk,
	input  wire logic       link_valid,
	input  wire logic       link_rw,
	input  wire logic [1:0] link_register_group_select,
	input  wire logic [7:0] link_data,
	// Device pins and analog status
	input  wire logic       spi_select,
	input  wire logic       address_strap_high,
	input  wire logic       address_strap_low,
	input  wire logic       reset_pin,
	input  wire logic [7:0] temperature_value,
	input  wire logic       display_on_status,
	input  wire logic       pump_charged_status,
	// Read answer
	output logic      [7:0] status_byte,
	output logic            status_valid,
	// Settings
	output logic            pump_enable,
	output logic      [2:0] pump_multiplier,
	output logic      [2:0] pump_gain,
	output logic            readout_select,
	output logic            sticky_reset_flag
);

	localparam int SW = 27;

	// Synchronised inputs
	logic [SW-1:0] raw_in;
	logic [SW-1:0] sync_out;
	logic          link_clk_s;
	logic          link_valid_s;
	lcd_cmd_pkg::cmd_frame_s frame_s;
	logic          spi_s;
	logic          strap_high_s;
	logic          strap_low_s;
	logic          reset_pin_s;
	logic [7:0]    temperature_s;
	logic          display_s;
	logic          charged_s;

	assign raw_in = {link_clk, link_valid, link_rw, link_register_group_select, link_data,
	                 spi_select, address_strap_high, address_strap_low, reset_pin,
	                 temperature_value, display_on_status, pump_charged_status};

	sync_bits #(
		.W (SW)
	) u_sync (
		.mclk (mclk),
		.rst  (rst),
		.d    (raw_in),
		.q    (sync_out)
	);

	assign {link_clk_s, link_valid_s, frame_s, spi_s, strap_high_s, strap_low_s, reset_pin_s,
	        temperature_s, display_s, charged_s} = sync_out;

	// Link edge detection and frame capture
	lcd_cmd_pkg::ctl_state_e state_reg;
	lcd_cmd_pkg::ctl_state_e state_next;
	lcd_cmd_pkg::cmd_frame_s frame_reg;
	lcd_cmd_pkg::cmd_frame_s frame_next;
	logic                    link_prev_reg;
	logic                    link_rise;

	assign link_rise = link_clk_s && !link_prev_reg;

	always_comb begin
		state_next = state_reg;
		frame_next = frame_reg;
		case (state_reg)
			lcd_cmd_pkg::ST_IDLE: begin
				if (link_rise && link_valid_s) begin
					frame_next = frame_s;
					state_next = lcd_cmd_pkg::ST_EXEC;
				end
			end
			lcd_cmd_pkg::ST_EXEC: begin
				state_next = lcd_cmd_pkg::ST_IDLE;
			end
			default: begin
				state_next = lcd_cmd_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg     <= lcd_cmd_pkg::ST_IDLE;
			frame_reg     <= '0;
			link_prev_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			frame_reg     <= frame_next;
			link_prev_reg <= link_clk_s;
		end
	end

	// Command decode
	lcd_cmd_pkg::cmd_decode_s dec;
	logic                     exec;

	cmd_decode u_decode (
		.frame (frame_reg),
		.dec   (dec)
	);

	assign exec = (state_reg == lcd_cmd_pkg::ST_EXEC);

	// Settings and sticky flag
	lcd_cmd_pkg::pump_cfg_s pump_cfg_reg;
	lcd_cmd_pkg::pump_cfg_s pump_cfg_next;
	logic                   read_sel_reg;
	logic                   read_sel_next;
	logic                   flag_reg;
	logic                   flag_next;
	logic [2:0]             gain_reg;
	logic [2:0]             gain_next;
	logic                   soft_reset;

	always_comb begin
		pump_cfg_next = pump_cfg_reg;
		read_sel_next = read_sel_reg;
		flag_next     = flag_reg;
		soft_reset    = reset_pin_s || (exec && dec.initialize);
		if (exec && dec.pump_ctrl) begin
			pump_cfg_next.pump_enable     = frame_reg.data[`PUMP_EN_BIT];
			pump_cfg_next.pump_multiplier = frame_reg.data[`PUMP_MULT_HI:`PUMP_MULT_LO];
		end
		if (exec && dec.read_select) begin
			read_sel_next = frame_reg.data[`READ_SEL_BIT];
		end
		if (exec && dec.clear_flag) begin
			flag_next = 1'b0;
		end
		if (soft_reset) begin
			pump_cfg_next.pump_enable     = `PUMP_EN_RST;
			pump_cfg_next.pump_multiplier = `PUMP_MULT_RST;
			read_sel_next                 = `READ_SEL_RST;
			flag_next                     = 1'b1;
		end
		case (pump_cfg_next.pump_multiplier)
			`MULT_X2: gain_next = `GAIN_X2;
			`MULT_X3: gain_next = `GAIN_X3;
			`MULT_X4: gain_next = `GAIN_X4;
			`MULT_X5: gain_next = `GAIN_X5;
			default:  gain_next = `GAIN_X1;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pump_cfg_reg <= {`PUMP_EN_RST, `PUMP_MULT_RST};
			read_sel_reg <= `READ_SEL_RST;
			flag_reg     <= `RESET_FLAG_RST;
			gain_reg     <= `GAIN_X2;
		end else begin
			pump_cfg_reg <= pump_cfg_next;
			read_sel_reg <= read_sel_next;
			flag_reg     <= flag_next;
			gain_reg     <= gain_next;
		end
	end

	// Live status and read answer
	logic [7:0] live_status;
	logic [7:0] status_reg;
	logic [7:0] status_next;
	logic       valid_reg;
	logic       valid_next;

	always_comb begin
		live_status = temperature_s;
		if (read_sel_reg != `SEL_TEMPERATURE) begin
			live_status[`ST_DISPLAY]    = display_s;
			live_status[`ST_PUMP_ON]    = pump_cfg_reg.pump_enable;
			live_status[`ST_PUMP_READY] = charged_s;
			live_status[`ST_RESET_FLAG] = flag_reg;
			if (spi_s) begin
				live_status[`ST_CODE_HI:`ST_CODE_LO] = `CODE_SPI;
			end else begin
				live_status[`ST_CODE_HI:`ST_CODE_LO] = {`CODE_I2C_TOP, strap_high_s, strap_low_s};
			end
		end
		status_next = status_reg;
		valid_next  = 1'b0;
		if (exec && dec.status_read) begin
			status_next = live_status;
			valid_next  = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			status_reg <= `STATUS_RST;
			valid_reg  <= 1'b0;
		end else begin
			status_reg <= status_next;
			valid_reg  <= valid_next;
		end
	end

	// Outputs
	assign status_byte       = status_reg;
	assign status_valid      = valid_reg;
	assign pump_enable       = pump_cfg_reg.pump_enable;
	assign pump_multiplier   = pump_cfg_reg.pump_multiplier;
	assign pump_gain         = gain_reg;
	assign readout_select    = read_sel_reg;
	assign sticky_reset_flag = flag_reg;

	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	logic rd_temp;
	logic rd_dev;
	assign rd_temp = exec && dec.status_read && (read_sel_reg == `SEL_TEMPERATURE);
	assign rd_dev  = exec && dec.status_read && (read_sel_reg != `SEL_TEMPERATURE);

	a_read_answer: assert property (link_rise && link_valid_s && !exec && (frame_s.rw == `RW_READ) &&
		(frame_s.register_group_select == `RS_GENERAL) |-> ##2 valid_reg ##1 !valid_reg)
		else $error("read not answered by one valid pulse");
	a_temp_value: assert property (rd_temp |=> status_reg == $past(temperature_s))
		else $error("temperature readout wrong");
	a_display_bit: assert property (rd_dev |=> status_reg[`ST_DISPLAY] == $past(display_s))
		else $error("display bit wrong");
	a_pump_bit: assert property (rd_dev |=> status_reg[`ST_PUMP_ON] == $past(pump_cfg_reg.pump_enable))
		else $error("pump enable bit wrong");
	a_charged_bit: assert property (rd_dev |=> status_reg[`ST_PUMP_READY] == $past(charged_s))
		else $error("pump charged bit wrong");
	a_flag_bit: assert property (rd_dev |=> status_reg[`ST_RESET_FLAG] == $past(flag_reg))
		else $error("reset flag bit wrong");
	a_flag_set: assert property ((reset_pin_s || (exec && dec.initialize)) |=> flag_reg && !pump_cfg_reg.pump_enable)
		else $error("reset did not set flag");
	a_code_i2c: assert property (rd_dev && !spi_s |=>
		status_reg[`ST_CODE_HI:`ST_CODE_LO] == {`CODE_I2C_TOP, $past(strap_high_s), $past(strap_low_s)})
		else $error("I2C check code wrong");
	a_code_spi: assert property (rd_dev && spi_s |=> status_reg[`ST_CODE_HI:`ST_CODE_LO] == `CODE_SPI)
		else $error("SPI check code wrong");
	a_flag_clear: assert property (exec && dec.clear_flag && !reset_pin_s |=> !flag_reg)
		else $error("flag not cleared");
	a_pump_load: assert property (exec && dec.pump_ctrl && !reset_pin_s |=>
		pump_cfg_reg == $past(frame_reg.data[`PUMP_EN_BIT:`PUMP_MULT_LO]))
		else $error("pump settings not loaded");
	a_gain_map: assert property (pump_cfg_reg.pump_multiplier[2] |-> gain_reg == `GAIN_X1)
		else $error("direct mode gain wrong");
	a_select_store: assert property (exec && dec.read_select && !reset_pin_s |=>
		read_sel_reg == $past(frame_reg.data[`READ_SEL_BIT]))
		else $error("readout select not stored");
	a_unknown_hold: assert property (exec && !dec.pump_ctrl && !dec.read_select && !dec.clear_flag &&
		!dec.initialize && !reset_pin_s |=> $stable(pump_cfg_reg) && $stable(read_sel_reg) && $stable(flag_reg))
		else $error("unknown command changed settings");

	// Answer framing, gain and pin defaults
	a_valid_once: assert property (valid_reg |=> !valid_reg)
		else $error("answer pulse longer than one cycle");
	a_valid_cause: assert property (valid_reg |-> $past(rd_temp || rd_dev))
		else $error("answer without a status read");
	a_status_hold: assert property (!(exec && dec.status_read) |=> $stable(status_reg))
		else $error("status byte changed without a read");
	a_gain_mult: assert property (!pump_cfg_reg.pump_multiplier[2] |->
		gain_reg == pump_cfg_reg.pump_multiplier + `GAIN_X2)
		else $error("multiplier gain wrong");
	a_pin_defaults: assert property (reset_pin_s |=>
		(pump_cfg_reg.pump_multiplier == `PUMP_MULT_RST) && (read_sel_reg == `READ_SEL_RST))
		else $error("reset pin did not restore defaults");

	c_read_temp: cover property (rd_temp ##1 valid_reg);
	c_read_dev: cover property (rd_dev ##1 valid_reg);
	c_clear_flag: cover property (exec && dec.clear_flag ##1 !flag_reg);
	c_pump_on: cover property (exec && dec.pump_ctrl ##1 pump_cfg_reg.pump_enable);
	c_direct_mode: cover property (exec && dec.pump_ctrl ##1 pump_cfg_reg.pump_multiplier[2]);

endmodule

// [bench/lcd_host_model.sv]
/*
 Host side of the command link: frames one command byte per link clock rise.
 Assumes mclk runs at 100 ns; the link clock runs at 800 ns only inside a frame.
*/
`timescale 1ns/1ps
module lcd_host_model (
	// Clock
	input  wire logic       mclk,
	// Command link
	output logic            link_clk,
	output logic            link_valid,
	output logic            link_rw,
	output logic      [1:0] link_register_group_select,
	output logic      [7:0] link_data
);
	initial begin
		link_clk = 1'b0;
		link_valid = 1'b0;
		link_rw = 1'b0;
		link_register_group_select = 2'h0;
		link_data = 8'h00;
	end

	// Frame held across the rise, then released with inverted levels
	task automatic send(input logic rw, input logic [1:0] grp, input logic [7:0] d);
		@(negedge mclk);
		link_valid = 1'b1;
		link_rw = rw;
		link_register_group_select = grp;
		link_data = d;
		repeat (4) @(negedge mclk);
		link_clk = 1'b1;
		repeat (4) @(negedge mclk);
		link_clk = 1'b0;
		link_valid = 1'b0;
		link_rw = ~rw;
		link_register_group_select = ~grp;
		link_data = ~d;
		repeat (4) @(negedge mclk);
	endtask
endmodule

// [bench/lcd_status_and_pump_cmds_tb.sv]
/*
 Self-checking bench of the status and charge pump command block.
 Assumes the host model drives the link and pin levels change at mclk falls.
*/
`timescale 1ns/1ps
`include "lcd_cfg.svh"
module lcd_status_and_pump_cmds_tb;
	logic       mclk, rst, link_clk, link_valid, link_rw;
	logic [1:0] link_register_group_select;
	logic [7:0] link_data, temperature_value, status_byte, got;
	logic       spi_select, address_strap_high, address_strap_low, reset_pin;
	logic       display_on_status, pump_charged_status, status_valid;
	logic       pump_enable, readout_select, sticky_reset_flag, pen;
	logic [2:0] pump_multiplier, pump_gain;
	int         n_mismatch = 0, n_tests = 0, n_got = 0, k;

	lcd_host_model host (.mclk(mclk), .link_clk(link_clk), .link_valid(link_valid), .link_rw(link_rw),
		.link_register_group_select(link_register_group_select), .link_data(link_data));

	lcd_status_and_pump_cmds dut (.mclk(mclk), .rst(rst), .link_clk(link_clk), .link_valid(link_valid),
		.link_rw(link_rw), .link_register_group_select(link_register_group_select), .link_data(link_data),
		.spi_select(spi_select), .address_strap_high(address_strap_high),
		.address_strap_low(address_strap_low), .reset_pin(reset_pin), .temperature_value(temperature_value),
		.display_on_status(display_on_status), .pump_charged_status(pump_charged_status),
		.status_byte(status_byte), .status_valid(status_valid), .pump_enable(pump_enable),
		.pump_multiplier(pump_multiplier), .pump_gain(pump_gain), .readout_select(readout_select),
		.sticky_reset_flag(sticky_reset_flag));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	always @(negedge mclk) begin
		if (status_valid === 1'b1) begin
			got <= status_byte;
			n_got <= n_got + 1;
		end
	end

	function automatic logic [2:0] gain_of(input logic [2:0] m);
		return m[2] ? 3'h1 : m + 3'h2;
	endfunction

	function automatic logic [7:0] dev_status(input logic pe, input logic flag);
		return {display_on_status, pe, pump_charged_status, flag,
			spi_select ? 4'h5 : {2'h1, address_strap_high, address_strap_low}};
	endfunction

	task automatic test_done;
		if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk_set(input logic pe, input logic [2:0] m, input logic flag);
		chk({pump_enable, pump_gain, pump_multiplier, sticky_reset_flag}, {pe, gain_of(m), m, flag});
	endtask

	// One read, exactly one answer expected
	task automatic rd(input logic [7:0] e);
		int k0;
		k0 = n_got;
		host.send(`RW_READ, `RS_GENERAL, 8'($urandom));
		chk(8'(n_got - k0), 8'h01);
		chk(got, e);
	endtask

	task automatic pulse_reset_pin;
		reset_pin = 1'b1;
		repeat (4) @(negedge mclk);
		reset_pin = 1'b0;
		repeat (4) @(negedge mclk);
	endtask

	initial begin
		rst = 1'b1;
		{spi_select, address_strap_high, address_strap_low, reset_pin} = 4'h0;
		{display_on_status, pump_charged_status, temperature_value} = 10'h000;
		void'($urandom(1681));
		repeat (6) @(negedge mclk);
		rst = 1'b0;
		repeat (3) @(negedge mclk);
		chk_set(1'b0, 3'h0, 1'b1);
		chk({7'h0, readout_select}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			temperature_value = (i == 3) ? 8'hff : 8'($urandom);
			rd(temperature_value);
		end
		for (int i = 0; i < 8; i++) begin
			pen = 1'($urandom);
			host.send(`RW_WRITE, `RS_GENERAL, {4'hc, pen, 3'(i)});
			chk_set(pen, 3'(i), 1'b1);
		end
		host.send(`RW_WRITE, `RS_GENERAL, {7'h0e, 1'b1});
		chk({7'h0, readout_select}, 8'h01);
		for (int i = 0; i < 6; i++) begin
			{spi_select, address_strap_high, address_strap_low} = 3'($urandom);
			{display_on_status, pump_charged_status, temperature_value} = 10'($urandom);
			if (i < 2) spi_select = 1'(i);
			rd(dev_status(pen, 1'b1));
		end
		host.send(`RW_WRITE, `RS_GENERAL, `CMD_CLEAR_FLAG);
		chk_set(pen, 3'h7, 1'b0);
		rd(dev_status(pen, 1'b0));
		k = n_got;
		host.send(`RW_WRITE, 2'h1, {4'hc, ~pen, 3'h2});
		host.send(`RW_WRITE, 2'h3, `CMD_INITIALIZE);
		host.send(`RW_WRITE, `RS_GENERAL, 8'hd8);
		host.send(`RW_WRITE, 2'h2, {7'h0e, 1'b0});
		host.send(`RW_READ, 2'h1, 8'h00);
		chk(8'(n_got - k), 8'h00);
		chk_set(pen, 3'h7, 1'b0);
		chk({7'h0, readout_select}, 8'h01);
		host.send(`RW_WRITE, `RS_GENERAL, `CMD_INITIALIZE);
		chk_set(1'b0, 3'h0, 1'b1);
		host.send(`RW_WRITE, `RS_GENERAL, `CMD_CLEAR_FLAG);
		host.send(`RW_WRITE, `RS_GENERAL, 8'hcd);
		chk_set(1'b1, 3'h5, 1'b0);
		pulse_reset_pin();
		chk_set(1'b0, 3'h0, 1'b1);
		host.send(`RW_WRITE, `RS_GENERAL, `CMD_CLEAR_FLAG);
		rst = 1'b1;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		repeat (3) @(negedge mclk);
		chk_set(1'b0, 3'h0, 1'b1);
		test_done();
	end

	initial begin
		#500000;
		n_mismatch++;
		test_done();
	end
endmodule
